// file: logic/apc_pkg.sv
// Package with constants, states and the checksum step for the parallel host port.
package apc_pkg;

  // Clock period and conversion time, each in nanoseconds.
  localparam int CLK_PERIOD_NS = 4;
  localparam int CONV_TIME_NS = 2000;
  // Least conversion time rounded up to whole cycles, never below one.
  localparam int CONV_CYCLES_RAW = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CYCLES = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;
  localparam int CNT_W = 12;

  // Cycles after reset release before the strap filter has settled.
  // Three synchroniser stages plus the agreement stage need four edges.
  localparam logic [2:0] STRAP_WAIT = 3'h4;

  // Fixed self-test patterns for the two converters.
  localparam logic [15:0] SELFTEST_A = 16'hAAAA;
  localparam logic [15:0] SELFTEST_B = 16'h5555;

  // Checksum seed at the start of every converted pair.
  localparam logic [7:0] CRC_SEED = 8'h00;

  // Range straps value that selects software mode.
  localparam logic [1:0] RANGE_SW_MODE = 2'h0;

  // Command word layout: read flag and register address.
  localparam int CMD_READ_BIT = 15;
  localparam int CMD_ADDR_MSB = 14;
  localparam int CMD_ADDR_LSB = 9;
  localparam int ADDR_W = CMD_ADDR_MSB - CMD_ADDR_LSB + 1;

  // Positions within the synchronised pin vector.
  localparam int PIN_DATA_LSB = 0;
  localparam int PIN_DATA_MSB = 15;
  localparam int PIN_CS = 16;
  localparam int PIN_RD = 17;
  localparam int PIN_WR = 18;
  localparam int PIN_CONV = 19;
  localparam int PIN_RANGE_LSB = 20;
  localparam int PIN_RANGE_MSB = 21;
  localparam int PIN_IFSEL = 22;
  localparam int PIN_BYTE = 23;
  localparam int PIN_CHECKSUM_ENABLE = 24;
  localparam int PIN_W = 25;

  // Readout slot order after a conversion.
  localparam logic [1:0] SLOT_A = 2'h0;
  localparam logic [1:0] SLOT_B = 2'h1;
  localparam logic [1:0] SLOT_STATUS = 2'h2;
  localparam logic [1:0] SLOT_DONE = 2'h3;

  // Main states of the port.
  typedef enum logic [1:0] {
    ST_STRAP = 2'b00,
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } apc_state_e;

  // One checksum update over a 16-bit result word.
  function automatic logic [7:0] apc_crc_step(input logic [15:0] d, input logic [7:0] c);
    logic [7:0] o;
    o[0] = d[14]^d[12]^d[8]^d[7]^d[6]^d[0]^c[0]^c[4]^c[6];
    o[1] = d[15]^d[14]^d[13]^d[12]^d[9]^d[6]^d[1]^d[0]^c[1]^c[4]^c[5]^c[6]^c[7];
    o[2] = d[15]^d[13]^d[12]^d[10]^d[8]^d[6]^d[2]^d[1]^d[0]^c[0]^c[2]^c[4]^c[5]^c[7];
    o[3] = d[14]^d[13]^d[11]^d[9]^d[7]^d[3]^d[2]^d[1]^c[1]^c[3]^c[5]^c[6];
    o[4] = d[15]^d[14]^d[12]^d[10]^d[8]^d[4]^d[3]^d[2]^c[0]^c[2]^c[4]^c[6]^c[7];
    o[5] = d[15]^d[13]^d[11]^d[9]^d[5]^d[4]^c[2]^c[4]^c[3]^c[5]^c[7];
    o[6] = d[14]^d[12]^d[10]^d[6]^d[5]^d[4]^c[2]^c[4]^c[6];
    o[7] = d[15]^d[13]^d[11]^d[7]^d[6]^d[5]^c[3]^c[5]^c[7];
    return o;
  endfunction

endpackage

// file: logic/apc_port.sv
// Device-side 16-bit parallel host port with self test and checksum status word.
//
// Summary of operation
// RL1 - Self test forces A to AAAA, B to 5555.
// RL2 - Self test only honoured in software mode.
// RL3 - Hardware mode checksum only on serial interface.
// RL4 - Checksum and status word enable each other.
// RL5 - Checksum strap sampled at full reset release.
// RL6 - Hardware checksum appends status word after results.
// RL7 - Software checksum on when either enable bit set.
// RL8 - Checksum covers A, B; sent after them.
// RL9 - Checksum starts zero, A first then B.
// RL10 - Each update is the fixed XOR network.
// RL11 - Status word delivered by one extra read.
// RL12 - Range straps zero select software mode.
// RL13 - Host holds interface strap low for parallel.
// RL14 - Hardware mode delivers conversion data only.
// RL15 - Start rising edge begins conversion, raises busy.
// RL16 - Drive data only while select and read low.
// RL17 - Select rise tristates, select fall releases bus; the code starts driving after select fall if read is low.
// RL18 - Host reads at least two words per conversion.
// RL19 - First read fall gives A, next gives B.
// RL20 - Writes only in software mode, taken at write rise.
// RL21 - Read command latches address, register then driven.
// RL22 - Register accesses only accepted in software mode.
// RL23 - Host keeps select low across register access.
`timescale 1ns/1ps
module apc_port #(
  parameter int CONV_CYCLES = apc_pkg::CONV_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic cs_n_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic conversion_start_in,
  input wire logic [15:0] parallel_data_bus_in,
  input wire logic [1:0] range_select_straps_in,
  input wire logic interface_select_strap_in,
  input wire logic byte_mode_strap_in,
  input wire logic checksum_enable_strap_in,
  input wire logic cfg_checksum_enable_in,
  input wire logic cfg_status_word_enable_in,
  input wire logic cfg_selftest_in,
  input wire logic [7:0] status_info_in,
  input wire logic [15:0] adc_a_result_in,
  input wire logic [15:0] adc_b_result_in,
  input wire logic [15:0] reg_rd_data_in,
  output logic [15:0] parallel_data_bus_out,
  output logic parallel_data_bus_oe_out,
  output logic busy_out,
  output logic sample_start_out,
  output logic reg_wr_stb_out,
  output logic [15:0] reg_wr_word_out,
  output logic [apc_pkg::ADDR_W-1:0] reg_rd_addr_out,
  output logic sw_mode_out,
  output logic parallel_if_out,
  output logic checksum_active_out
);

  // Width of the conversion cycle counter.
  localparam int CNT_W = apc_pkg::CNT_W;

  // Whole state of the port in one record.
  typedef struct packed {
    logic [apc_pkg::PIN_W-1:0] s1;        // First synchroniser stage.
    logic [apc_pkg::PIN_W-1:0] s2;        // Second synchroniser stage.
    logic [apc_pkg::PIN_W-1:0] s3;        // Third synchroniser stage.
    logic [apc_pkg::PIN_W-1:0] flt;       // Agreed pin levels.
    logic [apc_pkg::PIN_W-1:0] flt_d;     // Agreed levels one cycle back.
    apc_pkg::apc_state_e state;           // Main state.
    logic [2:0] strap_wait;               // Settling count after reset.
    logic sw_mode;                        // Latched software mode.
    logic par_if;                         // Latched parallel interface choice.
    logic crc_strap;                      // Latched checksum strap.
    logic serial_if;                      // Latched serial interface choice.
    logic [apc_pkg::CNT_W-1:0] cnt;       // Conversion cycle count.
    logic [15:0] res_a;                   // Held A result.
    logic [15:0] res_b;                   // Held B result.
    logic [7:0] crc;                      // Checksum of the last pair.
    logic crc_on;                         // Status word appended.
    logic [1:0] slot;                     // Next readout slot.
    logic rd_pend;                        // Register read command pending.
    logic [apc_pkg::ADDR_W-1:0] rd_addr;  // Latched register address.
    logic [15:0] dout;                    // Output stage.
    logic oe;                             // Bus drive enable.
    logic busy;                           // Conversion in progress.
    logic start;                          // Sample start pulse.
    logic wr_stb;                         // Register write pulse.
    logic [15:0] wr_word;                 // Captured write word.
  } apc_state_s;

  apc_state_s st_r;
  apc_state_s st_nxt;

  // Edge and level terms from the filtered pins, plus the result pair and the checksum after A.
  logic cs_low;
  logic rd_fall;
  logic wr_rise;
  logic conv_rise;
  logic [15:0] bus_word;
  logic [7:0] crc_mid;
  logic [15:0] pair_a;
  logic [15:0] pair_b;

  // Decoding of filtered pins, shared by the next-state process.
  always_comb begin
    cs_low = ~st_r.flt[apc_pkg::PIN_CS];
    rd_fall = st_r.flt_d[apc_pkg::PIN_RD] & ~st_r.flt[apc_pkg::PIN_RD];
    wr_rise = ~st_r.flt_d[apc_pkg::PIN_WR] & st_r.flt[apc_pkg::PIN_WR];
    conv_rise = ~st_r.flt_d[apc_pkg::PIN_CONV] & st_r.flt[apc_pkg::PIN_CONV];
    bus_word = st_r.flt[apc_pkg::PIN_DATA_MSB:apc_pkg::PIN_DATA_LSB];
  end

  // Result source: fixed patterns replace the converter in software self test.
  always_comb begin
    if (st_r.sw_mode && cfg_selftest_in) begin // [RL1] [RL2]
      pair_a = apc_pkg::SELFTEST_A;
      pair_b = apc_pkg::SELFTEST_B;
    end else begin
      pair_a = adc_a_result_in;
      pair_b = adc_b_result_in;
    end
    // A goes in first, its result seeds the B step.
    crc_mid = apc_pkg::apc_crc_step(pair_a, apc_pkg::CRC_SEED); // [RL9] [RL10]
  end

  // Next-state logic for the whole port.
  always_comb begin
    st_nxt = st_r;
    st_nxt.start = 1'b0;
    st_nxt.wr_stb = 1'b0;

    // Pins from the host cross in through three stages; a bit is taken once
    // the second and third stages agree, which filters single-cycle glitches.
    st_nxt.s1 = {checksum_enable_strap_in, byte_mode_strap_in, interface_select_strap_in,
                 range_select_straps_in, conversion_start_in, wr_n_in, rd_n_in, cs_n_in,
                 parallel_data_bus_in};
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < apc_pkg::PIN_W; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.flt[i] = st_r.s3[i];
      end
    end
    st_nxt.flt_d = st_r.flt;

    // Software mode keeps the checksum tied to either enable bit; hardware
    // mode only offers it on the serial interface, never on this port.
    if (st_r.sw_mode) begin
      st_nxt.crc_on = cfg_checksum_enable_in | cfg_status_word_enable_in; // [RL7] [RL4] [RL3]
    end else begin
      st_nxt.crc_on = st_r.crc_strap & st_r.serial_if; // [RL3] [RL5] [RL6]
    end

    case (st_r.state)
      apc_pkg::ST_STRAP: begin
        // Straps are caught once the filter has seen settled levels.
        if (st_r.strap_wait == apc_pkg::STRAP_WAIT) begin
          st_nxt.sw_mode = (st_r.flt[apc_pkg::PIN_RANGE_MSB:apc_pkg::PIN_RANGE_LSB]
                            == apc_pkg::RANGE_SW_MODE); // [RL12]
          st_nxt.par_if = ~st_r.flt[apc_pkg::PIN_IFSEL]; // [RL13]
          st_nxt.serial_if = st_r.flt[apc_pkg::PIN_IFSEL] & ~st_r.flt[apc_pkg::PIN_BYTE];
          st_nxt.crc_strap = st_r.flt[apc_pkg::PIN_CHECKSUM_ENABLE]; // [RL5]
          st_nxt.state = apc_pkg::ST_IDLE;
        end else begin
          st_nxt.strap_wait = st_r.strap_wait + 3'h1;
        end
      end
      apc_pkg::ST_IDLE: begin
        // A rising start edge opens a conversion and raises busy.
        if (conv_rise) begin // [RL15]
          st_nxt.state = apc_pkg::ST_CONV;
          st_nxt.busy = 1'b1;
          st_nxt.start = 1'b1;
          st_nxt.cnt = '0;
        end
      end
      apc_pkg::ST_CONV: begin
        // At the end the pair and its checksum are held for readout.
        if (st_r.cnt == CNT_W'(CONV_CYCLES - 1)) begin
          st_nxt.state = apc_pkg::ST_IDLE;
          st_nxt.busy = 1'b0; // [RL15]
          st_nxt.res_a = pair_a;
          st_nxt.res_b = pair_b;
          st_nxt.crc = apc_pkg::apc_crc_step(pair_b, crc_mid); // [RL8] [RL9] [RL10]
          st_nxt.slot = apc_pkg::SLOT_A;
        end else begin
          st_nxt.cnt = st_r.cnt + CNT_W'(1);
        end
      end
      default: begin
        st_nxt.state = apc_pkg::ST_STRAP;
      end
    endcase

    // Host strobes only matter on the parallel interface after straps are set.
    if (st_r.par_if && st_r.state != apc_pkg::ST_STRAP) begin
      // Read falling edge loads the next word into the output stage.
      if (cs_low && rd_fall) begin
        if (st_r.rd_pend) begin
          st_nxt.dout = reg_rd_data_in; // [RL21]
          st_nxt.rd_pend = 1'b0;
        end else begin
          case (st_r.slot)
            apc_pkg::SLOT_A: begin
              st_nxt.dout = st_r.res_a; // [RL19]
              st_nxt.slot = apc_pkg::SLOT_B;
            end
            apc_pkg::SLOT_B: begin
              st_nxt.dout = st_r.res_b; // [RL19]
              st_nxt.slot = st_r.crc_on ? apc_pkg::SLOT_STATUS : apc_pkg::SLOT_DONE;
            end
            apc_pkg::SLOT_STATUS: begin
              // One extra read carries the status word with the checksum.
              st_nxt.dout = {status_info_in, st_r.crc}; // [RL11] [RL8] [RL4] [RL6]
              st_nxt.slot = apc_pkg::SLOT_DONE;
            end
            default: begin
              // Reads past the last word simply repeat the output stage.
              st_nxt.slot = apc_pkg::SLOT_DONE;
            end
          endcase
        end
      end
      // Write rising edge: register commands, honoured only in software mode.
      if (cs_low && wr_rise && st_r.sw_mode) begin // [RL20] [RL22] [RL14]
        if (bus_word[apc_pkg::CMD_READ_BIT]) begin
          st_nxt.rd_addr = bus_word[apc_pkg::CMD_ADDR_MSB:apc_pkg::CMD_ADDR_LSB]; // [RL21]
          st_nxt.rd_pend = 1'b1;
        end else begin
          st_nxt.wr_word = bus_word; // [RL20]
          st_nxt.wr_stb = 1'b1;
        end
      end
      // Ending the select drops a half-finished register read.
      if (!cs_low) begin
        st_nxt.rd_pend = 1'b0;
      end
      // Drive only with both select and read low; select rise lets go.
      st_nxt.oe = cs_low & ~st_r.flt[apc_pkg::PIN_RD]; // [RL16] [RL17]
    end else begin
      st_nxt.oe = 1'b0;
    end
  end

  // The single register bank; asynchronous reset to constants only.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r <= '0;
      st_r.s1 <= '1;
      st_r.s2 <= '1;
      st_r.s3 <= '1;
      st_r.flt <= '1;
      st_r.flt_d <= '1;
      st_r.state <= apc_pkg::ST_STRAP;
      st_r.slot <= apc_pkg::SLOT_DONE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Every output comes straight from the state record.
  assign parallel_data_bus_out = st_r.dout;
  assign parallel_data_bus_oe_out = st_r.oe;
  assign busy_out = st_r.busy;
  assign sample_start_out = st_r.start;
  assign reg_wr_stb_out = st_r.wr_stb;
  assign reg_wr_word_out = st_r.wr_word;
  assign reg_rd_addr_out = st_r.rd_addr;
  assign sw_mode_out = st_r.sw_mode;
  assign parallel_if_out = st_r.par_if;
  assign checksum_active_out = st_r.crc_on;

endmodule

// file: tb/apc_host.sv
// Host controller model that drives the parallel port strobes and data.
`timescale 1ns/1ps
module apc_host (
  input wire logic clk_in,
  input wire logic busy_in,
  input wire logic oe_in,
  input wire logic [15:0] bus_in,
  output logic cs_n_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic conv_out,
  output logic [15:0] drive_out
);
  int n;
  // Select, read and write idle high, start idles low; the bus word idles at a value nobody waits for.
  initial begin
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    conv_out = 1'b0;
    drive_out = 16'h0000;
  end
  // Chip select is held low across a whole access sequence by the caller.
  task automatic sel(input logic v);
    cs_n_out <= v;
  endtask
  // Start a conversion and read nothing until busy has dropped again.
  task automatic conv();
    conv_out <= 1'b1;
    repeat (6) @(posedge clk_in);
    conv_out <= 1'b0;
    n = 0;
    do @(negedge clk_in); while (busy_in !== 1'b0 && ++n < 100);
    @(posedge clk_in);
  endtask
  // One read: the word is taken just before read rises, then release waits for tristate.
  task automatic rd(output logic [15:0] d);
    rd_n_out <= 1'b0;
    n = 0;
    do @(negedge clk_in); while (oe_in !== 1'b1 && ++n < 12);
    repeat (2) @(negedge clk_in);
    d = bus_in;
    @(posedge clk_in) rd_n_out <= 1'b1;
    n = 0;
    do @(negedge clk_in); while (oe_in !== 1'b0 && ++n < 12);
    @(posedge clk_in);
  endtask
  // One write word; data stays until the device has seen the rising strobe.
  task automatic wr(input logic [15:0] w);
    drive_out <= w;
    wr_n_out <= 1'b0;
    repeat (3) @(posedge clk_in);
    wr_n_out <= 1'b1;
    repeat (6) @(posedge clk_in);
    drive_out <= ~w; // Released lines show the inverse, never the last word.
    @(posedge clk_in);
  endtask
endmodule

// file: tb/apc_port_assertions.sv
// Concurrent checks on the ports of the parallel host port.
`timescale 1ns/1ps
module apc_port_checker #(
  parameter int CONV_CYCLES = 8
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic cs_n_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic [15:0] parallel_data_bus_in,
  input wire logic [1:0] range_select_straps_in,
  input wire logic interface_select_strap_in,
  input wire logic parallel_data_bus_oe_out,
  input wire logic busy_out,
  input wire logic sample_start_out,
  input wire logic reg_wr_stb_out,
  input wire logic sw_mode_out,
  input wire logic parallel_if_out,
  input wire logic checksum_active_out
);
  logic [11:0] busy_len_r;
  // Length of the current busy period, so its full span can be checked.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy_len_r <= 12'h000;
    end else begin
      busy_len_r <= busy_out ? busy_len_r + 12'h001 : 12'h000;
    end
  end
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rstn_in);
  property p_oe_off;
    (cs_n_in || rd_n_in) [*6] |-> !parallel_data_bus_oe_out;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("bus driven while idle");
  property p_oe_on;
    (!cs_n_in && !rd_n_in) [*6] ##0 parallel_if_out |-> parallel_data_bus_oe_out;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("bus not driven");
  property p_cs_rise;
    $rose(cs_n_in) |-> ##[1:5] !parallel_data_bus_oe_out;
  endproperty
  a_cs_rise: assert property (p_cs_rise) else $error("bus kept after select rise");
  property p_busy_len;
    $fell(busy_out) |-> busy_len_r == CONV_CYCLES;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  property p_start_pair;
    sample_start_out == $rose(busy_out);
  endproperty
  a_start_pair: assert property (p_start_pair) else $error("start pulse apart from busy");
  property p_wr_sw;
    reg_wr_stb_out |-> sw_mode_out;
  endproperty
  a_wr_sw: assert property (p_wr_sw) else $error("write taken in hardware mode");
  property p_wr_resp;
    $rose(wr_n_in) && !cs_n_in && sw_mode_out && !parallel_data_bus_in[15] |-> ##[2:6] reg_wr_stb_out;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write word not captured");
  property p_mode_sw;
    $rose(rstn_in) |-> ##8 sw_mode_out == (range_select_straps_in == 2'h0);
  endproperty
  a_mode_sw: assert property (p_mode_sw) else $error("mode latch wrong");
  property p_mode_par;
    $rose(rstn_in) |-> ##8 parallel_if_out == !interface_select_strap_in;
  endproperty
  a_mode_par: assert property (p_mode_par) else $error("interface latch wrong");
  property p_crc_hw;
    !sw_mode_out && parallel_if_out |-> !checksum_active_out;
  endproperty
  a_crc_hw: assert property (p_crc_hw) else $error("checksum on hardware parallel");
  c_conv: cover property (sample_start_out);
  c_read: cover property ($rose(parallel_data_bus_oe_out));
  c_write: cover property (reg_wr_stb_out);
endmodule
bind apc_port apc_port_checker #(.CONV_CYCLES(CONV_CYCLES)) u_apc_port_checker (
  .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .cs_n_in(cs_n_in), .rd_n_in(rd_n_in),
  .wr_n_in(wr_n_in), .parallel_data_bus_in(parallel_data_bus_in),
  .range_select_straps_in(range_select_straps_in),
  .interface_select_strap_in(interface_select_strap_in),
  .parallel_data_bus_oe_out(parallel_data_bus_oe_out), .busy_out(busy_out),
  .sample_start_out(sample_start_out), .reg_wr_stb_out(reg_wr_stb_out),
  .sw_mode_out(sw_mode_out), .parallel_if_out(parallel_if_out),
  .checksum_active_out(checksum_active_out));

// file: tb/testbench.sv
// Self-checking bench for the parallel host port.
`timescale 1ns/1ps
module testbench;
  typedef struct {logic st; logic ce; logic se; logic [15:0] a; logic [15:0] b;} apc_row_s;
  // Each checksum bit is the parity of the masked {data, checksum} vector.
  localparam logic [23:0] MASK [8] = '{24'h51C151, 24'hF243F2, 24'hB547B5, 24'h6A8E6A,
    24'hD51CD5, 24'hAA30BC, 24'h547054, 24'hA8E0A8};
  apc_row_s rows [6] = '{'{1'b0, 1'b0, 1'b0, 16'h1234, 16'h5678},
    '{1'b0, 1'b1, 1'b0, 16'hFFFF, 16'h0000}, '{1'b0, 1'b0, 1'b1, 16'h8001, 16'h7FFE},
    '{1'b1, 1'b0, 1'b0, 16'h1111, 16'h2222}, '{1'b1, 1'b1, 1'b1, 16'h0000, 16'h0000},
    '{1'b0, 1'b1, 1'b1, 16'hA5A5, 16'h5A5A}};
  logic sys_clk_in = 1'b0, rstn_in = 1'b0, ifsel = 1'b0, cstrap = 1'b0;
  logic cfg_st = 1'b0, cfg_ce = 1'b0, cfg_se = 1'b0, bstrap = 1'b0;
  logic [7:0] sinfo = 8'h3C;
  wire sstart;
  int start_cnt = 0;
  logic [1:0] rng = 2'h0;
  logic [15:0] a_res = 16'h0000, b_res = 16'h0000, reg_data = 16'h0000, ea, eb, d;
  wire cs_n, rd_n, wr_n, conv, oe, busy, stb, swm, parif, cka;
  wire [15:0] drv, dout, wword, bus;
  wire [5:0] rd_addr;
  int error_cnt = 0, n_tests = 0, stb_cnt = 0;
  assign bus = oe ? dout : drv; // The device's stage wins while it drives.
  apc_port #(.CONV_CYCLES(8)) u_apc_port (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
    .cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n), .conversion_start_in(conv),
    .parallel_data_bus_in(bus), .range_select_straps_in(rng), .interface_select_strap_in(ifsel),
    .byte_mode_strap_in(bstrap), .checksum_enable_strap_in(cstrap),
    .cfg_checksum_enable_in(cfg_ce), .cfg_status_word_enable_in(cfg_se),
    .cfg_selftest_in(cfg_st), .status_info_in(sinfo), .adc_a_result_in(a_res),
    .adc_b_result_in(b_res), .reg_rd_data_in(reg_data), .parallel_data_bus_out(dout),
    .parallel_data_bus_oe_out(oe), .busy_out(busy), .sample_start_out(sstart),
    .reg_wr_stb_out(stb),
    .reg_wr_word_out(wword), .reg_rd_addr_out(rd_addr), .sw_mode_out(swm),
    .parallel_if_out(parif), .checksum_active_out(cka));
  apc_host u_apc_host (.clk_in(sys_clk_in), .busy_in(busy), .oe_in(oe), .bus_in(bus),
    .cs_n_out(cs_n), .rd_n_out(rd_n), .wr_n_out(wr_n), .conv_out(conv), .drive_out(drv));
  initial forever #2 sys_clk_in = ~sys_clk_in;
  // Count write strobes so refused writes show as a missing increment.
  always @(posedge sys_clk_in) if (stb === 1'b1) stb_cnt++;
  // Count sample start pulses; each conversion must give exactly one.
  always @(posedge sys_clk_in) if (sstart === 1'b1) start_cnt++;
  function automatic logic [7:0] crc8(input logic [15:0] dw, input logic [7:0] c);
    for (int i = 0; i < 8; i++) crc8[i] = ^({dw, c} & MASK[i]);
  endfunction
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Full reset with new straps; they stay put well past the latch point.
  task automatic boot(input logic [1:0] r, input logic f, input logic c);
    rstn_in <= 1'b0;
    rng <= r;
    ifsel <= f;
    cstrap <= c;
    repeat (10) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    repeat (12) @(posedge sys_clk_in);
  endtask
  task automatic conclude();
    if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Conversion and three reads with the given results loaded.
  task automatic run3(input logic [15:0] a, input logic [15:0] b);
    a_res <= a;
    b_res <= b;
    u_apc_host.conv();
    u_apc_host.sel(1'b0);
    u_apc_host.rd(ea);
    u_apc_host.rd(eb);
    u_apc_host.rd(d);
  endtask
  initial begin
    @(posedge sys_clk_in);
    boot(2'h0, 1'b0, 1'b0);
    chk("sw_mode", 16'h0001, {15'h0, swm});
    for (int i = 0; i < 6; i++) begin
      cfg_st <= rows[i].st;
      cfg_ce <= rows[i].ce;
      cfg_se <= rows[i].se;
      run3(rows[i].a, rows[i].b);
      chk("result_a", rows[i].st ? 16'hAAAA : rows[i].a, ea);
      chk("result_b", rows[i].st ? 16'h5555 : rows[i].b, eb);
      chk("status", (rows[i].ce | rows[i].se) ? {sinfo, crc8(eb, crc8(ea, 8'h00))} : eb, d);
      u_apc_host.sel(1'b1);
    end
    chk("start_count", 16'h0006, start_cnt[15:0]);
    u_apc_host.sel(1'b0);
    u_apc_host.wr(16'h1234);
    chk("wr_word", 16'h1234, wword);
    chk("wr_count", 16'h0001, stb_cnt[15:0]);
    reg_data <= 16'hBEEF;
    u_apc_host.wr(16'hD400);
    chk("rd_addr", 16'h002A, {10'h0, rd_addr});
    u_apc_host.rd(d);
    chk("reg_read", 16'hBEEF, d);
    u_apc_host.rd_n_out <= 1'b0;
    repeat (8) @(negedge sys_clk_in);
    chk("oe_held", 16'h0001, {15'h0, oe});
    @(posedge sys_clk_in) u_apc_host.sel(1'b1);
    repeat (6) @(negedge sys_clk_in);
    chk("oe_cs_rise", 16'h0000, {15'h0, oe});
    @(posedge sys_clk_in) u_apc_host.rd_n_out <= 1'b1;
    boot(2'h1, 1'b0, 1'b1);
    chk("hw_checksum", 16'h0000, {15'h0, cka});
    cfg_st <= 1'b1;
    run3(16'h0F0F, 16'hF0F0);
    chk("hw_a", 16'h0F0F, ea);
    chk("hw_b", 16'hF0F0, eb);
    chk("hw_third", 16'hF0F0, d);
    u_apc_host.wr(16'h4321);
    chk("hw_wr_count", 16'h0001, stb_cnt[15:0]);
    u_apc_host.sel(1'b1);
    boot(2'h1, 1'b1, 1'b1);
    chk("serial_checksum", 16'h0001, {15'h0, cka});
    u_apc_host.sel(1'b0);
    u_apc_host.rd(d);
    chk("serial_oe", 16'h0000, {15'h0, oe});
    bstrap <= 1'b1;
    boot(2'h1, 1'b1, 1'b1);
    chk("byte_checksum", 16'h0000, {15'h0, cka});
    conclude();
  end
  // A hang past 25000 cycles, far beyond the few hundred the run needs, counts as a failure.
  initial begin
    #100us;
    error_cnt++;
    conclude();
  end
endmodule
